// >>> design/fg_function_gen.sv
// Notes on behaviour
// [RULE1] One command (wave, amplitude, offset, period) is the only control.
// [RULE2] Selector: 0 off, 1 steady, 2 up, 3 down, 4 triangle, 5 square, 6 sine.
// [RULE3] Non-sine amplitude is peak-to-peak in 2.4 mV steps, 0 to 1667.
// [RULE4] Non-sine offset is a base level in -1.2 mV steps, 0 to 3333.
// [RULE5] Period is one cycle in ms, 5 to 2000.
// [RULE6] Output is 2.4 mV times shaped amplitude minus 1.2 mV times offset.
// [RULE7] Selector 1 holds a constant level.
// [RULE8] Selector 0 releases the output instead of driving zero.
// [RULE9] Sine comes from a table, other shapes are computed.
// [RULE10] Sine amplitude 0, 1, 2 gives 8, 4, 2 V peak-to-peak.
// [RULE11] A positive-only shape uses offset zero, amplitude peak over 2.4 mV.
// [RULE12] A negative level uses selector 1, zero amplitude, offset over -1.2 mV.
// [RULE13] A command replaces all four parameters and restarts the cycle.
`include "fg_consts.svh"
`default_nettype none

module fg_function_gen #(
  parameter int CYC_PER_MS = `FG_CYC_PER_MS, // Clock cycles per millisecond
  parameter int ADDR_W     = 8               // AXI address width
) (
  input  wire logic              CLK,           // System clock
  input  wire logic              RST,           // Asynchronous reset, active high
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,  // Write address
  input  wire logic              S_AXI_AWVALID, // Write address valid
  output var  logic              S_AXI_AWREADY, // Write address ready
  input  wire logic [31:0]       S_AXI_WDATA,   // Write data
  input  wire logic [3:0]        S_AXI_WSTRB,   // Write byte strobes
  input  wire logic              S_AXI_WVALID,  // Write data valid
  output var  logic              S_AXI_WREADY,  // Write data ready
  output var  logic [1:0]        S_AXI_BRESP,   // Write response
  output var  logic              S_AXI_BVALID,  // Write response valid
  input  wire logic              S_AXI_BREADY,  // Write response ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,  // Read address
  input  wire logic              S_AXI_ARVALID, // Read address valid
  output var  logic              S_AXI_ARREADY, // Read address ready
  output var  logic [31:0]       S_AXI_RDATA,   // Read data
  output var  logic [1:0]        S_AXI_RRESP,   // Read response
  output var  logic              S_AXI_RVALID,  // Read data valid
  input  wire logic              S_AXI_RREADY,  // Read data ready
  output var fg_pkg::fg_code_type AO_CODE,      // Output level, 1.2 mV steps
  output var  logic              AO_DRIVE,      // Output stage drives the line
  output var  logic              AO_CYCLE       // Pulse at each cycle start
);

  // ********************
  // Elaboration checks
  // ********************
  if (CYC_PER_MS < `FG_CYC_MIN || ADDR_W < 5) begin : g_bad_param
    $error("fg_function_gen: CYC_PER_MS below minimum or ADDR_W too narrow");
  end

  // ********************
  // Declarations
  // ********************
  logic [2:0]          wave_sh;
  logic [11:0]         ampl_sh;
  logic [11:0]         offs_sh;
  logic [11:0]         per_sh;
  logic [2:0]          sel;
  logic [11:0]         ampl;
  logic [11:0]         offs;
  logic [31:0]         ncyc;
  fg_pkg::fg_mode_type mode;
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   waddr;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                wr_go;
  logic                wr_ok;
  logic [31:0]         cmd_word;
  logic                commit;
  logic [31:0]         rd_val;
  logic                rd_ok;
  logic [11:0]         per_eff;
  logic [31:0]         cyc;
  logic                last;
  logic [31:0]         acc_r;
  logic [31:0]         acc_t;
  logic [31:0]         acc_s;
  logic [31:0]         sum_r;
  logic [31:0]         sum_t;
  logic [31:0]         sum_s;
  logic [11:0]         lvl_r;
  logic [12:0]         lvl_t;
  logic [6:0]          phase;
  fg_pkg::fg_sine_type sine_val;
  logic [1:0]          ssel;
  logic [12:0]         shaped;
  fg_pkg::fg_code_type next_code;

  // ********************
  // Helpers
  // ********************

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] fg_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : fg_merge

  // ********************
  // AXI4-Lite write channels
  // ********************

  // Address and data taken in either order, answer after both
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `FG_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      waddr         <= '0;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held       <= 1'b1;
        waddr         <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held       <= 1'b1;
        wdata        <= S_AXI_WDATA;
        wstrb        <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `FG_RESP_OKAY : `FG_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Write decode: which offsets take a write
  assign wr_go    = aw_held && w_held;
  assign cmd_word = fg_merge(32'h0000_0000, wdata, wstrb);
  always_comb begin
    if (waddr == ADDR_W'(`FG_REG_WAVE)) begin
      wr_ok = 1'b1;
    end else if (waddr == ADDR_W'(`FG_REG_AMPL)) begin
      wr_ok = 1'b1;
    end else if (waddr == ADDR_W'(`FG_REG_OFFS)) begin
      wr_ok = 1'b1;
    end else if (waddr == ADDR_W'(`FG_REG_PER)) begin
      wr_ok = 1'b1;
    end else if (waddr == ADDR_W'(`FG_REG_CMD)) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Only the one command code applies the parameters
  assign commit = wr_go && (waddr == ADDR_W'(`FG_REG_CMD))
                  && (cmd_word == `FG_CMD_CODE);  // see [RULE1]

  // Staged parameters, written freely before the command
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wave_sh <= `FG_WAVE_RST;
      ampl_sh <= `FG_AMPL_RST;
      offs_sh <= `FG_OFFS_RST;
      per_sh  <= `FG_PER_RST;
    end else if (wr_go) begin
      if (waddr == ADDR_W'(`FG_REG_WAVE)) begin
        wave_sh <= 3'(fg_merge({29'h0, wave_sh}, wdata, wstrb));
      end else if (waddr == ADDR_W'(`FG_REG_AMPL)) begin
        ampl_sh <= 12'(fg_merge({20'h0, ampl_sh}, wdata, wstrb));
      end else if (waddr == ADDR_W'(`FG_REG_OFFS)) begin
        offs_sh <= 12'(fg_merge({20'h0, offs_sh}, wdata, wstrb));
      end else if (waddr == ADDR_W'(`FG_REG_PER)) begin
        per_sh <= 12'(fg_merge({20'h0, per_sh}, wdata, wstrb));
      end
    end
  end

  // ********************
  // AXI4-Lite read channels
  // ********************

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (S_AXI_ARADDR == ADDR_W'(`FG_REG_WAVE)) begin
      rd_val = {29'h0, wave_sh};
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_AMPL)) begin
      rd_val = {20'h0, ampl_sh};
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_OFFS)) begin
      rd_val = {20'h0, offs_sh};
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_PER)) begin
      rd_val = {20'h0, per_sh};
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_CMD)) begin
      rd_val = 32'h0000_0000;
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_STAT)) begin
      rd_val = {27'h0, AO_DRIVE, 1'b0, sel};
    end else if (S_AXI_ARADDR == ADDR_W'(`FG_REG_CODE)) begin
      rd_val = {{17{AO_CODE[14]}}, AO_CODE};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Address taken, data one cycle later until taken
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `FG_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_val;
      S_AXI_RRESP   <= rd_ok ? `FG_RESP_OKAY : `FG_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ********************
  // Active parameters and mode
  // ********************

  // Period clamped to the shortest usable cycle
  assign per_eff = (per_sh < `FG_PER_MIN) ? `FG_PER_MIN : per_sh;  // see [RULE5]

  // All four parameters replaced at once on the command
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel  <= `FG_WAVE_OFF;
      ampl <= `FG_AMPL_RST;
      offs <= `FG_OFFS_RST;
      ncyc <= 32'h0000_0000;
      mode <= fg_pkg::FG_MODE_OFF;
    end else if (commit) begin
      sel  <= wave_sh;  // see [RULE13]
      ampl <= ampl_sh;  // see [RULE3]
      offs <= offs_sh;  // see [RULE4]
      ncyc <= 32'(per_eff) * 32'(CYC_PER_MS);  // see [RULE5]
      case (wave_sh)  // see [RULE2]
        `FG_WAVE_DC:      mode <= fg_pkg::FG_MODE_DC;
        `FG_WAVE_RAMP_UP: mode <= fg_pkg::FG_MODE_SHAPE;
        `FG_WAVE_RAMP_DN: mode <= fg_pkg::FG_MODE_SHAPE;
        `FG_WAVE_TRI:     mode <= fg_pkg::FG_MODE_SHAPE;
        `FG_WAVE_SQUARE:  mode <= fg_pkg::FG_MODE_SHAPE;
        `FG_WAVE_SINE:    mode <= fg_pkg::FG_MODE_SHAPE;
        default:          mode <= fg_pkg::FG_MODE_OFF;
      endcase
    end
  end

  // ********************
  // Cycle timing and shape accumulators
  // ********************
  assign last  = (cyc == ncyc - 32'h1);
  assign sum_r = acc_r + 32'(ampl);
  assign sum_t = acc_t + 32'({ampl, 1'b0});
  assign sum_s = acc_s + `FG_PHASE_STEPS;

  // Stepwise division: each level step after one share of the cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc   <= 32'h0000_0000;
      acc_r <= 32'h0000_0000;
      acc_t <= 32'h0000_0000;
      acc_s <= 32'h0000_0000;
      lvl_r <= 12'h000;
      lvl_t <= 13'h0000;
      phase <= 7'h00;
    end else if (commit || mode != fg_pkg::FG_MODE_SHAPE || last) begin
      cyc   <= 32'h0000_0000;  // see [RULE13]
      acc_r <= 32'h0000_0000;
      acc_t <= 32'h0000_0000;
      acc_s <= 32'h0000_0000;
      lvl_r <= 12'h000;
      lvl_t <= 13'h0000;
      phase <= 7'h00;
    end else begin
      cyc <= cyc + 32'h1;
      // Ramp climbs to the amplitude over the cycle
      if (sum_r >= ncyc) begin
        acc_r <= sum_r - ncyc;  // see [RULE9]
        lvl_r <= lvl_r + 12'h001;
      end else begin
        acc_r <= sum_r;
      end
      // Triangle base climbs to twice the amplitude
      if (sum_t >= ncyc) begin
        acc_t <= sum_t - ncyc;  // see [RULE9]
        lvl_t <= lvl_t + 13'h0001;
      end else begin
        acc_t <= sum_t;
      end
      // Sine table position
      if (sum_s >= ncyc) begin
        acc_s <= sum_s - ncyc;
        phase <= phase + 7'h01;
      end else begin
        acc_s <= sum_s;
      end
    end
  end

  // ********************
  // Sine table
  // ********************
  fg_sine_rom u_sine (
    .CLK   (CLK),
    .RST   (RST),
    .phase (phase),
    .value (sine_val)  // see [RULE9]
  );

  // ********************
  // Output level
  // ********************

  // Sine size picked by the amplitude, larger values give the smallest
  assign ssel = (ampl > `FG_SINE_SEL_MAX) ? 2'h2 : ampl[1:0];  // see [RULE10]

  // Shaped amplitude term
  always_comb begin
    case (sel)
      `FG_WAVE_RAMP_UP: shaped = {1'b0, lvl_r};
      `FG_WAVE_RAMP_DN: shaped = {1'b0, ampl - lvl_r};
      `FG_WAVE_TRI:     shaped = (lvl_t <= {1'b0, ampl}) ? lvl_t
                                 : 13'({ampl, 1'b0} - lvl_t);
      `FG_WAVE_SQUARE:  shaped = (cyc < {1'b0, ncyc[31:1]}) ? {1'b0, ampl} : 13'h0000;
      default:          shaped = {1'b0, ampl};  // see [RULE7]
    endcase
  end

  // Level in 1.2 mV steps: twice amplitude term less offset, for sine the table sample plus mid level less offset
  always_comb begin
    if (sel == `FG_WAVE_SINE) begin
      next_code = {{2{sine_val[12]}}, sine_val >>> ssel}  // see [RULE10]
                  + $signed(`FG_SINE_MID >> ssel)
                  - $signed({3'b000, offs});  // see [RULE10]
    end else begin
      next_code = $signed({1'b0, shaped, 1'b0})
                  - $signed({3'b000, offs});  // see [RULE6]
    end
  end

  // Registered outputs; off releases the line
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AO_CODE  <= 15'sh0000;
      AO_DRIVE <= 1'b0;
      AO_CYCLE <= 1'b0;
    end else begin
      case (mode)
        fg_pkg::FG_MODE_OFF: begin
          AO_CODE  <= 15'sh0000;
          AO_DRIVE <= 1'b0;  // see [RULE8]
        end
        default: begin
          AO_CODE  <= next_code;  // see [RULE6]
          AO_DRIVE <= 1'b1;
        end
      endcase
      AO_CYCLE <= commit || (last && mode == fg_pkg::FG_MODE_SHAPE);
    end
  end

endmodule : fg_function_gen

`default_nettype wire

// >>> pkg/fg_consts.svh
`ifndef FG_CONSTS_SVH
`define FG_CONSTS_SVH

// ********************
// Register byte offsets
// ********************
`define FG_REG_WAVE     8'h00
`define FG_REG_AMPL     8'h04
`define FG_REG_OFFS     8'h08
`define FG_REG_PER      8'h0c
`define FG_REG_CMD      8'h10
`define FG_REG_STAT     8'h14
`define FG_REG_CODE     8'h18

// ********************
// Field layout and reset values
// ********************
`define FG_CMD_CODE     32'h0000_0191
`define FG_STAT_DRIVE   4
`define FG_WAVE_RST     3'h0
`define FG_AMPL_RST     12'h000
`define FG_OFFS_RST     12'h000
`define FG_PER_RST      12'h000
`define FG_RESP_OKAY    2'h0
`define FG_RESP_SLVERR  2'h2

// ********************
// Waveform selector codes
// ********************
`define FG_WAVE_OFF     3'h0
`define FG_WAVE_DC      3'h1
`define FG_WAVE_RAMP_UP 3'h2
`define FG_WAVE_RAMP_DN 3'h3
`define FG_WAVE_TRI     3'h4
`define FG_WAVE_SQUARE  3'h5
`define FG_WAVE_SINE    3'h6

// ********************
// Sine sizes and timing
// ********************
`define FG_SINE_MID     15'h0c00
`define FG_SINE_SEL_MAX 12'h002
`define FG_PER_MIN      12'h005
`define FG_PHASE_STEPS  32'h0000_0080
`define FG_CLK_HZ       20000000
`define FG_PER_UNIT_MS  1
`define FG_CYC_PER_MS   (`FG_CLK_HZ / 1000 * `FG_PER_UNIT_MS)
`define FG_CYC_MIN      2048

`endif

// >>> pkg/fg_pkg.sv
`default_nettype none

package fg_pkg;

  // Generator operating mode
  typedef enum logic [1:0] {
    FG_MODE_OFF,
    FG_MODE_DC,
    FG_MODE_SHAPE
  } fg_mode_type;

  // Output code in steps of 1.2 mV, signed
  typedef logic signed [14:0] fg_code_type;

  // Signed sine sample from the table
  typedef logic signed [12:0] fg_sine_type;

endpackage : fg_pkg

`default_nettype wire

// >>> design/fg_sine_rom.sv
`default_nettype none

module fg_sine_rom (
  input  wire logic            CLK,   // System clock
  input  wire logic            RST,   // Asynchronous reset
  input  wire logic [6:0]      phase, // Position in one cycle
  output var fg_pkg::fg_sine_type value // Registered sine sample
);

  logic [4:0]  idx;
  logic [11:0] mag;

  // Quarter wave mirrored into the second and fourth quadrants
  assign idx = phase[5] ? ~phase[4:0] : phase[4:0];

  // Quarter wave table, full scale of about 4 V in 1.2 mV steps
  always_comb begin
    case (idx)
      5'h00: mag = 12'h052;  5'h01: mag = 12'h0f5;  5'h02: mag = 12'h198;
      5'h03: mag = 12'h23a;  5'h04: mag = 12'h2da;  5'h05: mag = 12'h379;
      5'h06: mag = 12'h415;  5'h07: mag = 12'h4b0;  5'h08: mag = 12'h547;
      5'h09: mag = 12'h5db;  5'h0a: mag = 12'h66b;  5'h0b: mag = 12'h6f7;
      5'h0c: mag = 12'h77f;  5'h0d: mag = 12'h803;  5'h0e: mag = 12'h881;
      5'h0f: mag = 12'h8fa;  5'h10: mag = 12'h96e;  5'h11: mag = 12'h9dc;
      5'h12: mag = 12'ha44;  5'h13: mag = 12'haa5;  5'h14: mag = 12'hb00;
      5'h15: mag = 12'hb54;  5'h16: mag = 12'hba1;  5'h17: mag = 12'hbe7;
      5'h18: mag = 12'hc26;  5'h19: mag = 12'hc5d;  5'h1a: mag = 12'hc8c;
      5'h1b: mag = 12'hcb4;  5'h1c: mag = 12'hcd4;  5'h1d: mag = 12'hcec;
      5'h1e: mag = 12'hcfc;  default: mag = 12'hd04;
    endcase
  end

  // Registered read, negative half by negation
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      value <= 13'sh0000;
    end else if (phase[6]) begin
      value <= -$signed({1'b0, mag});
    end else begin
      value <= $signed({1'b0, mag});
    end
  end

endmodule : fg_sine_rom

`default_nettype wire

// >>> tb/fg_function_gen_checker.sv
`include "fg_consts.svh"
`default_nettype none

// ********************
// Port checker of the function generator
// ********************
module fg_function_gen_checker #(
  parameter int ADDR_W = 8 // Address width
) (
  input wire logic                CLK,           // Clock
  input wire logic                RST,           // Reset
  input wire logic [ADDR_W-1:0]   S_AXI_AWADDR,  // Write address
  input wire logic                S_AXI_AWVALID, // Write address valid
  input wire logic                S_AXI_AWREADY, // Write address ready
  input wire logic [31:0]         S_AXI_WDATA,   // Write data
  input wire logic [3:0]          S_AXI_WSTRB,   // Write strobes
  input wire logic                S_AXI_WVALID,  // Write data valid
  input wire logic                S_AXI_WREADY,  // Write data ready
  input wire logic [1:0]          S_AXI_BRESP,   // Write response
  input wire logic                S_AXI_BVALID,  // Write response valid
  input wire logic                S_AXI_BREADY,  // Write response ready
  input wire logic [ADDR_W-1:0]   S_AXI_ARADDR,  // Read address
  input wire logic                S_AXI_ARVALID, // Read address valid
  input wire logic                S_AXI_ARREADY, // Read address ready
  input wire logic [31:0]         S_AXI_RDATA,   // Read data
  input wire logic [1:0]          S_AXI_RRESP,   // Read response
  input wire logic                S_AXI_RVALID,  // Read data valid
  input wire logic                S_AXI_RREADY,  // Read data ready
  input wire fg_pkg::fg_code_type AO_CODE,       // Output level
  input wire logic                AO_DRIVE,      // Output driven
  input wire logic                AO_CYCLE       // Cycle start pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // Bus answers and holds
  a_write_resp: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer not on time");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_write_stall: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("second write accepted early");
  a_read_resp: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer not on time");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed while waiting");
  a_unmapped_read: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > `FG_REG_CODE
    |=> S_AXI_RRESP == `FG_RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answered wrongly");
  // Output side
  a_cmd_restart: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY &&
    S_AXI_AWADDR == `FG_REG_CMD && S_AXI_WDATA == `FG_CMD_CODE && S_AXI_WSTRB == 4'hf
    |-> ##2 AO_CYCLE) else $error("command did not restart the cycle");
  a_cycle_pulse: assert property (
    AO_CYCLE |=> !AO_CYCLE) else $error("cycle pulse too long");
  a_off_level: assert property (
    !AO_DRIVE |-> AO_CODE == 15'h0000) else $error("level present while released");
endmodule : fg_function_gen_checker

bind fg_function_gen fg_function_gen_checker #(.ADDR_W(ADDR_W)) fg_function_gen_checker_inst (
  .CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
  .AO_CODE, .AO_DRIVE, .AO_CYCLE);

`default_nettype wire

// >>> tb/fg_out_stage_model.sv
`default_nettype none

// ********************
// Analog output stage model
// ********************
module fg_out_stage_model (
  input  wire logic                CLK,   // Clock
  input  wire logic                RST,   // Reset
  input  wire fg_pkg::fg_code_type code,  // Requested level
  input  wire logic                drive, // Stage enabled
  output var fg_pkg::fg_code_type  level, // Line level
  output var logic                 driven // Line is driven
);
  timeunit 1ns;
  timeprecision 1ns;

  // Follow the code while driven, invert every clock when released so the stale value returns on alternate clocks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      level  <= '0;
      driven <= 1'b0;
    end else begin
      level  <= drive ? code : ~level;
      driven <= drive;
    end
  end
endmodule : fg_out_stage_model

`default_nettype wire

// >>> tb/tb_fg_function_gen.sv
`include "fg_consts.svh"
`default_nettype none

// ********************
// Testbench of the function generator
// ********************
module tb_fg_function_gen;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 2048;    // Short millisecond
  localparam int N   = 5 * CPM; // Clocks in a 5 ms cycle
  logic                CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic                S_AXI_ARVALID, S_AXI_RREADY;
  logic [7:0]          S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]         S_AXI_WDATA, seed, expv;
  logic [3:0]          S_AXI_WSTRB;
  wire logic           S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire logic           S_AXI_RVALID, AO_DRIVE, AO_CYCLE, line_on;
  wire logic [1:0]     S_AXI_BRESP, S_AXI_RRESP;
  wire logic [31:0]    S_AXI_RDATA;
  fg_pkg::fg_code_type AO_CODE, line_lvl;
  int                  n_mismatch, samples_checked, n;
  int                  cycles = 0;
  int                  dc_a[5] = '{1000, 0, 0, 1667, 0};
  int                  dc_o[5] = '{0, 2000, 0, 3333, 0};

  fg_function_gen #(.CYC_PER_MS(CPM)) fg_function_gen_inst (
    .CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .AO_CODE, .AO_DRIVE, .AO_CYCLE);
  fg_out_stage_model fg_out_stage_model_inst (
    .CLK, .RST, .code(AO_CODE), .drive(AO_DRIVE), .level(line_lvl), .driven(line_on));

  // Clock and run limit
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic near(input string nm, input logic signed [31:0] seen, input int exp, tol);
    check(nm, 32'(seen > exp - tol && seen < exp + tol), 32'h1);
  endtask : near

  // Bus write with both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_AWVALID || S_AXI_WVALID);
    do @(posedge CLK); while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    check("write response", {30'h0, S_AXI_BRESP}, {30'h0, er});
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge CLK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    check(nm, S_AXI_RDATA, ed);
    check("read response", {30'h0, S_AXI_RRESP}, {30'h0, er});
  endtask : rd_chk

  // Stage four parameters and apply them with one command
  task automatic cmd(input logic [2:0] w, input int a, o, p);
    wr(`FG_REG_WAVE, 32'(w), 4'hf, 2'h0);
    wr(`FG_REG_AMPL, 32'(a), 4'hf, 2'h0);
    wr(`FG_REG_OFFS, 32'(o), 4'hf, 2'h0);
    wr(`FG_REG_PER, 32'(p), 4'hf, 2'h0);
    wr(`FG_REG_CMD, `FG_CMD_CODE, 4'hf, 2'h0);
  endtask : cmd

  task automatic probe(input int k, input string nm, input int exp, tol);
    repeat (k) @(posedge CLK);
    near(nm, 32'(AO_CODE), exp, tol);
  endtask : probe

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    seed = 32'hb75a;
    RST  = 1'b1;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk("reset value", 8'(4 * i), 32'h0, 2'h0);
    rd_chk("unmapped", 8'h1c, 32'h0, 2'h2);
    wr(`FG_REG_STAT, 32'h1, 4'hf, 2'h2);
    // Staged parameters with a random word and a single lane overwrite
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(8'(4 * i), seed, 4'hf, 2'h0);
      wr(8'(4 * i), ~seed, 4'h2, 2'h0);
      expv = {seed[31:16], ~seed[15:8], seed[7:0]} & ((i == 0) ? 32'h7 : 32'hfff);
      rd_chk("staged", 8'(4 * i), expv, 2'h0);
    end
    // Steady levels, positive, negative, zero, extreme and random
    seed     = lfsr(seed);
    dc_a[4]  = int'(seed % 1668);
    dc_o[4]  = int'((seed >> 12) % 3334);
    foreach (dc_a[i]) begin
      cmd(`FG_WAVE_DC, dc_a[i], dc_o[i], 0);
      @(posedge CLK);
      check("steady code", 32'(AO_CODE), 32'(2 * dc_a[i] - dc_o[i]));
      rd_chk("status", `FG_REG_STAT, 32'h11, 2'h0);
      rd_chk("code reg", `FG_REG_CODE, 32'(2 * dc_a[i] - dc_o[i]), 2'h0);
      check("line level", 32'(line_lvl), 32'(2 * dc_a[i] - dc_o[i]));
    end
    // Off releases the line
    cmd(`FG_WAVE_OFF, 500, 0, 0);
    repeat (2) @(posedge CLK);
    check("drive off", {31'h0, AO_DRIVE}, 32'h0);
    check("line off", {31'h0, line_on}, 32'h0);
    // Computed shapes at fixed points of the cycle
    cmd(`FG_WAVE_RAMP_UP, 1000, 0, 5);
    probe(N / 4, "ramp up", 500, 8);
    cmd(`FG_WAVE_RAMP_DN, 1000, 400, 5);
    probe(N / 4, "ramp down", 1100, 8);
    cmd(`FG_WAVE_TRI, 1000, 400, 6);
    probe(6 * CPM / 4, "triangle", 600, 8);
    cmd(`FG_WAVE_SQUARE, 1000, 400, 5);
    probe(N / 4, "square high", 1600, 2);
    probe(3 * N / 8, "square low", -400, 2);
    cmd(`FG_WAVE_SQUARE, 1000, 400, 5);
    probe(N / 4, "restart", 1600, 2);
    // Table sine in its three sizes, peak then zero crossing
    for (int s = 0; s < 3; s++) begin
      cmd(`FG_WAVE_SINE, s, 3072 >> s, 5);
      probe(N / 4 + 40, "sine peak", 3333 >> s, 8);
      probe(N / 4, "sine centre", -(82 >> s), 8);
    end
    // Cycle length from one cycle pulse to the next
    do @(posedge CLK); while (AO_CYCLE !== 1'b1);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (AO_CYCLE !== 1'b1);
    check("cycle length", 32'(n), 32'(N));
    complete_run();
  end
endmodule : tb_fg_function_gen

`default_nettype wire
